// *** stc_far_end.sv ***
// Purpose: Far-side model feeding dropped-frame pulses and receive halves.
// Assumes: Driven from the bench clock.
// Notes:   Pulses frame_dropped for n consecutive cycles after go.
`timescale 1ns/1ps
module stc_far_end (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [7:0] n,
  output logic frame_dropped,
  output logic [15:0] rx_first_half,
  output logic [15:0] rx_second_half
);
  logic [7:0] left = 8'h00;
  always @(posedge ref_clk) begin
    if (go) begin
      left <= n;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  assign frame_dropped = (left != 8'h00);
  // First word off the wire is the low half
  assign rx_first_half = 16'h5a5a;
  assign rx_second_half = 16'hc3c3;
endmodule // stc_far_end

// *** stc_params.svh ***
// Purpose: Offsets, fields, reset values and timing counts for the
//          system timer and counter register group.
// Assumes: 100 MHz ref_clk; 25 MHz tick made by dividing it.
// Notes:   Included by the package user files only.
`ifndef STC_PARAMS_SVH
`define STC_PARAMS_SVH
`define STC_OFS_TMR_CFG 8'h8c
`define STC_OFS_GPT_COUNT 8'h90
`define STC_OFS_HW_ORDER 8'h98
`define STC_OFS_FREE 8'h9c
`define STC_OFS_DROP 8'ha0
`define STC_OFS_INT_STS 8'hb0
`define STC_OFS_INT_MASK 8'hb4
`define STC_RUN_BIT 29
`define STC_PRELOAD_RST 16'hffff
`define STC_ORDER_SWAP 32'hffffffff
`define STC_INT_TIMER 0
`define STC_INT_DROP 1
`define STC_CLK_NS 10
`define STC_TICK_NS 40
`define STC_TICK_DIV (`STC_TICK_NS / `STC_CLK_NS)
`define STC_CLEAR_NS 160
`endif

// *** stc_pkg.sv ***
// Purpose: Types shared by the timer and counter register group.
// Assumes: Nothing beyond the header.
// Notes:   Types only; numbers live in the header.
package stc_pkg;
  typedef enum logic [1:0] {
    stc_half_none,
    stc_half_low,
    stc_half_high
  } stc_half_t;
endpackage

// *** stc_regs.sv ***
// Purpose: Host registers for the general purpose timer, halfword order,
//          free tick counter and dropped-frame counter.
// Assumes: Plain register port; read data one cycle after read strobe.
// Notes:   bus16 selects 16-bit host mode, a1 is host address bit 1.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "stc_params.svh"
module stc_regs (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic bus16,
  input wire logic a1,
  input wire logic [15:0] host_wdata16,
  output logic [15:0] host_rdata16,
  input wire logic [31:0] tx_word,
  output logic [15:0] tx_first_half,
  output logic [15:0] tx_second_half,
  input wire logic [15:0] rx_first_half,
  input wire logic [15:0] rx_second_half,
  output logic [31:0] rx_word,
  input wire logic frame_dropped,
  output logic irq
);
  logic tick;
  logic run;
  logic [15:0] preload;
  logic [15:0] count;
  logic [31:0] hw_order;
  logic [31:0] free_cnt;
  logic [31:0] free_latch;
  logic free_latched;
  logic [31:0] drop_cnt;
  logic [1:0] int_sts;
  logic [1:0] int_mask;
  logic [1:0] next_sts;
  logic timer_evt;
  logic drop_evt;
  logic wr_cfg;
  logic rd_drop;
  logic rd_free;
  stc_pkg::stc_half_t half;

  stc_tick_gen i_stc_tick_gen (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(tick)
  );

  // Picks which word half a 16-bit access addresses
  function automatic stc_pkg::stc_half_t half_sel(
    input logic b16,
    input logic addr1,
    input logic [31:0] order
  );
    if (!b16) begin
      half_sel = stc_pkg::stc_half_none;
    end else if (order == `STC_ORDER_SWAP) begin
      half_sel = addr1 ? stc_pkg::stc_half_low
                       : stc_pkg::stc_half_high;
    end else begin
      half_sel = addr1 ? stc_pkg::stc_half_high
                       : stc_pkg::stc_half_low;
    end
  endfunction

  assign half = half_sel(bus16, a1, hw_order);
  assign wr_cfg = wr && (addr == `STC_OFS_TMR_CFG);
  assign rd_drop = rd && (addr == `STC_OFS_DROP);
  assign rd_free = rd && (addr == `STC_OFS_FREE);

  // Run enable and preload
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run <= 1'b0;
      preload <= `STC_PRELOAD_RST;
    end else if (wr_cfg) begin
      run <= wdata[`STC_RUN_BIT];
      if (run && !wdata[`STC_RUN_BIT]) begin
        preload <= `STC_PRELOAD_RST;
      end else begin
        preload <= wdata[15:0];
      end
    end
  end

  // Down counter with reload at zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count <= `STC_PRELOAD_RST;
    end else if (wr_cfg && !run && wdata[`STC_RUN_BIT]) begin
      count <= wdata[15:0];
    end else if (run && tick) begin
      if (count == 16'h0000) begin
        count <= preload;
      end else begin
        count <= count - 16'h0001;
      end
    end
  end

  assign timer_evt = run && tick && (count == 16'h0000);

  // Halfword order register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hw_order <= 32'h0000_0000;
    end else if (wr && addr == `STC_OFS_HW_ORDER) begin
      hw_order <= wdata;
    end
  end

  // Free tick counter, ungated
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      free_cnt <= 32'h0000_0000;
    end else if (tick) begin
      free_cnt <= free_cnt + 32'h0000_0001;
    end
  end

  // First 16-bit read latches the whole count, second uses it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      free_latch <= 32'h0000_0000;
      free_latched <= 1'b0;
    end else if (rd_free && bus16) begin
      if (!free_latched) begin
        free_latch <= free_cnt;
      end
      free_latched <= !free_latched;
    end
  end

  // Dropped-frame tally; a drop beside the clearing read is kept
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      drop_cnt <= 32'h0000_0000;
    end else if (rd_drop) begin
      drop_cnt <= {31'h0, frame_dropped};
    end else if (frame_dropped) begin
      drop_cnt <= drop_cnt + 32'h0000_0001;
    end
  end

  assign drop_evt = frame_dropped && !rd_drop &&
                    (drop_cnt == 32'h7fff_ffff);

  // Sticky status, write one to clear, set wins
  always_comb begin
    next_sts = int_sts;
    if (wr && addr == `STC_OFS_INT_STS) begin
      next_sts = int_sts & ~wdata[1:0];
    end
    next_sts[`STC_INT_TIMER] = next_sts[`STC_INT_TIMER] | timer_evt;
    next_sts[`STC_INT_DROP] = next_sts[`STC_INT_DROP] | drop_evt;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      int_sts <= 2'h0;
    end else begin
      int_sts <= next_sts;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      int_mask <= 2'h0;
    end else if (wr && addr == `STC_OFS_INT_MASK) begin
      int_mask <= wdata[1:0];
    end
  end

  assign irq = |(int_sts & int_mask);

  // Register read, data in the following cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      unique case (addr)
        `STC_OFS_TMR_CFG: rdata <= {2'h0, run, 13'h0, preload};
        `STC_OFS_GPT_COUNT: rdata <= {16'h0, count};
        `STC_OFS_HW_ORDER: rdata <= hw_order;
        `STC_OFS_FREE: rdata <= (bus16 && free_latched) ?
                                free_latch : free_cnt;
        `STC_OFS_DROP: rdata <= drop_cnt;
        `STC_OFS_INT_STS: rdata <= {30'h0, int_sts};
        `STC_OFS_INT_MASK: rdata <= {30'h0, int_mask};
        default: rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // 16-bit lane view of the read data for a narrow host
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      host_rdata16 <= 16'h0000;
    end else begin
      unique case (half)
        stc_pkg::stc_half_high: host_rdata16 <= rdata[31:16];
        stc_pkg::stc_half_low: host_rdata16 <= rdata[15:0];
        stc_pkg::stc_half_none: host_rdata16 <= 16'h0000;
      endcase
    end
  end

  // Fixed network word order, independent of host order
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_first_half <= 16'h0000;
      tx_second_half <= 16'h0000;
      rx_word <= 32'h0000_0000;
    end else begin
      tx_first_half <= tx_word[15:0];
      tx_second_half <= tx_word[31:16];
      rx_word <= {rx_second_half, rx_first_half};
    end
  end

  // Assertions
  sequence s_run_write;
    wr_cfg && wdata[`STC_RUN_BIT];
  endsequence
  sequence s_stop_write;
    wr_cfg && run && !wdata[`STC_RUN_BIT];
  endsequence
  sequence s_start_write;
    wr_cfg && !run && wdata[`STC_RUN_BIT];
  endsequence
  sequence s_plain;
    bus16 && hw_order != `STC_ORDER_SWAP;
  endsequence
  sequence s_swapped;
    bus16 && hw_order == `STC_ORDER_SWAP;
  endsequence

  // Timer
  a_run_start: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_run_write |=> run)
    else $error("timer did not start");
  a_run_load: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_start_write |=> count == $past(wdata[15:0]))
    else $error("count not seeded from preload");
  a_stop_preload: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_stop_write |=> !run && preload == `STC_PRELOAD_RST)
    else $error("preload not restored on stop");
  a_count_step: assert property (
    @(posedge ref_clk) disable iff (rst)
    run && tick && count != 16'h0 && !wr_cfg |=>
    count == $past(count) - 16'h1)
    else $error("count did not step down");
  a_count_reload: assert property (
    @(posedge ref_clk) disable iff (rst)
    timer_evt && !wr_cfg |=> count == $past(preload)
    && int_sts[`STC_INT_TIMER])
    else $error("no reload or flag at zero");
  a_halted_hold: assert property (
    @(posedge ref_clk) disable iff (rst)
    !run && !wr_cfg |=> $stable(count))
    else $error("halted timer moved");
  a_count_view: assert property (
    @(posedge ref_clk) disable iff (rst)
    rd && addr == `STC_OFS_GPT_COUNT |=> rdata == {16'h0, $past(count)})
    else $error("count read wrong");

  // Interrupt status
  a_timer_flag: assert property (
    @(posedge ref_clk) disable iff (rst)
    timer_evt |=> int_sts[`STC_INT_TIMER])
    else $error("timer flag not set");
  a_flag_clear: assert property (
    @(posedge ref_clk) disable iff (rst)
    wr && addr == `STC_OFS_INT_STS && wdata[`STC_INT_TIMER] && !timer_evt
    |=> !int_sts[`STC_INT_TIMER])
    else $error("timer flag not cleared");

  // Free tick counter
  a_free_step: assert property (
    @(posedge ref_clk) disable iff (rst)
    tick |=> free_cnt == $past(free_cnt) + 32'h1)
    else $error("free counter missed tick");
  a_free_hold: assert property (
    @(posedge ref_clk) disable iff (rst)
    !tick |=> $stable(free_cnt))
    else $error("free counter moved between ticks");
  a_free_latch: assert property (
    @(posedge ref_clk) disable iff (rst)
    rd_free && bus16 && !free_latched |=> free_latch == $past(free_cnt))
    else $error("free count not latched");
  a_free_pair: assert property (
    @(posedge ref_clk) disable iff (rst)
    rd_free && bus16 && free_latched |=> rdata == $past(free_latch))
    else $error("second half not from latch");

  // Dropped-frame tally
  a_drop_clear: assert property (
    @(posedge ref_clk) disable iff (rst)
    rd_drop && !frame_dropped |=> drop_cnt == 32'h0 &&
    rdata == $past(drop_cnt))
    else $error("drop counter read wrong");
  a_drop_inc: assert property (
    @(posedge ref_clk) disable iff (rst)
    frame_dropped && !rd_drop |=> drop_cnt == $past(drop_cnt) + 32'h1)
    else $error("drop not counted");
  a_drop_hold: assert property (
    @(posedge ref_clk) disable iff (rst)
    !frame_dropped && !rd_drop |=> $stable(drop_cnt))
    else $error("drop counter moved without a drop");
  a_drop_mid: assert property (
    @(posedge ref_clk) disable iff (rst)
    $rose(drop_cnt[31]) && !$past(rd_drop) |-> int_sts[`STC_INT_DROP])
    else $error("midpoint flag missing");

  // Lane order
  a_wide_zero: assert property (
    @(posedge ref_clk) disable iff (rst)
    !bus16 |=> host_rdata16 == 16'h0000)
    else $error("narrow lane active in wide mode");
  a_plain_high: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_plain ##0 a1 |=> host_rdata16 == $past(rdata[31:16]))
    else $error("plain high lane wrong");
  a_plain_low: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_plain ##0 !a1 |=> host_rdata16 == $past(rdata[15:0]))
    else $error("plain low lane wrong");
  a_half_swap: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_swapped ##0 a1 |=> host_rdata16 == $past(rdata[15:0]))
    else $error("swapped lane wrong");
  a_swap_high: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_swapped ##0 !a1 |=> host_rdata16 == $past(rdata[31:16]))
    else $error("swapped high lane wrong");
  a_tx_order: assert property (
    @(posedge ref_clk) disable iff (rst)
    !rst |=> tx_first_half == $past(tx_word[15:0])
    && tx_second_half == $past(tx_word[31:16]))
    else $error("transmit halves out of order");
  a_rx_order: assert property (
    @(posedge ref_clk) disable iff (rst)
    !rst |=> rx_word[15:0] == $past(rx_first_half)
    && rx_word[31:16] == $past(rx_second_half))
    else $error("receive halves out of order");
endmodule // stc_regs

// *** stc_tick_gen.sv ***
// Purpose: Makes a one-cycle pulse at the 25 MHz tick rate.
// Assumes: ref_clk at 100 MHz.
// Notes:   Never gated by any power state.
`timescale 1ns/1ps
`include "stc_params.svh"
module stc_tick_gen (
  input wire logic ref_clk,
  input wire logic rst,
  output logic tick
);
  localparam logic [3:0] DIV_LAST = 4'(`STC_TICK_DIV - 1);
  logic [3:0] div;

  // Free-running divider feeding the counters
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div <= 4'h0;
    end else if (div == DIV_LAST) begin
      div <= 4'h0;
    end else begin
      div <= div + 4'h1;
    end
  end

  assign tick = (div == DIV_LAST);

  a_tick_spacing: assert property (@(posedge ref_clk) disable iff (rst)
    tick |=> !tick [*3] ##1 tick)
    else $error("tick spacing wrong");
endmodule // stc_tick_gen

// *** test_sys_timers_counters_swap.sv ***
// Purpose: Self-checking bench for the timer and counter register group.
// Assumes: 100 MHz ref_clk, tick every 4 clocks.
// Notes:   Midpoint crossing of the drop counter is left to assertions.
`timescale 1ns/1ps
`include "stc_params.svh"
module test_sys_timers_counters_swap;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic bus16 = 1'b0;
  logic a1 = 1'b0;
  logic [31:0] tx_word = 32'h0;
  logic go = 1'b0;
  logic [7:0] n = 8'h00;
  logic [31:0] rdata, rx_word;
  logic [15:0] h16, txf, txs, rxf, rxs;
  logic fd, irq;
  int cyc = 0;
  int mismatches = 0;
  int checks = 0;
  stc_regs i_stc_regs (.ref_clk(ref_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .bus16(bus16),
    .a1(a1), .host_wdata16(16'h0000), .host_rdata16(h16),
    .tx_word(tx_word), .tx_first_half(txf), .tx_second_half(txs),
    .rx_first_half(rxf), .rx_second_half(rxs), .rx_word(rx_word),
    .frame_dropped(fd), .irq(irq));
  stc_far_end i_stc_far_end (.ref_clk(ref_clk), .go(go), .n(n),
    .frame_dropped(fd), .rx_first_half(rxf), .rx_second_half(rxs));
  always #5 ref_clk = ~ref_clk;
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches = mismatches + 1;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks = checks + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // Read data one cycle after the strobe, narrow half one cycle later
  task automatic rreg(input logic [7:0] a, output logic [31:0] d,
                      output logic [15:0] h);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge ref_clk);
    #1 h = h16;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [15:0] h;
    rreg(a, d, h);
    chk("register", e, d);
  endtask
  task automatic wait_irq(output int t);
    repeat (100) begin
      @(posedge ref_clk);
      #1;
      if (irq === 1'b1) break;
    end
    t = cyc;
    chk("irq", 32'h1, {31'h0, irq});
  endtask
  task automatic t_reset();
    // Reset lasts 200 ns, longer than the counter clear time
    rchk(`STC_OFS_FREE, 32'h0);
    rchk(`STC_OFS_TMR_CFG, 32'h0000ffff);
    rchk(`STC_OFS_GPT_COUNT, 32'h0000ffff);
    rchk(`STC_OFS_HW_ORDER, 32'h0);
    rchk(`STC_OFS_DROP, 32'h0);
    rchk(8'h04, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test reset done");
  endtask
  task automatic t_timer();
    logic [31:0] d1, d2;
    logic [15:0] h;
    int t0, t1;
    wreg(`STC_OFS_INT_MASK, 32'h3);
    wreg(`STC_OFS_TMR_CFG, 32'h20000003);
    wait_irq(t0);
    wreg(`STC_OFS_INT_STS, 32'h1);
    wait_irq(t1);
    chk("period", 32'd16, t1 - t0);
    rchk(`STC_OFS_INT_STS, 32'h1);
    wreg(`STC_OFS_TMR_CFG, 32'h00000003);
    rchk(`STC_OFS_TMR_CFG, 32'h0000ffff);
    rreg(`STC_OFS_GPT_COUNT, d1, h);
    repeat (8) @(posedge ref_clk);
    rreg(`STC_OFS_GPT_COUNT, d2, h);
    chk("halted count", d1, d2);
    wreg(`STC_OFS_INT_STS, 32'h1);
    @(posedge ref_clk);
    #1 chk("irq", 32'h0, {31'h0, irq});
    $display("test timer done");
  endtask
  task automatic half(input logic ha1, input logic [15:0] e);
    logic [31:0] d;
    logic [15:0] h;
    @(posedge ref_clk);
    a1 <= ha1;
    rreg(`STC_OFS_TMR_CFG, d, h);
    chk("narrow half", {16'h0, e}, {16'h0, h});
  endtask
  task automatic t_free();
    logic [31:0] d1, d2;
    logic [15:0] h;
    rreg(`STC_OFS_FREE, d1, h);
    repeat (5) @(posedge ref_clk);
    rreg(`STC_OFS_FREE, d2, h);
    chk("free step", d1 + 32'd2, d2);
    @(posedge ref_clk);
    bus16 <= 1'b1;
    rreg(`STC_OFS_FREE, d1, h);
    repeat (5) @(posedge ref_clk);
    rreg(`STC_OFS_FREE, d2, h);
    chk("free latch", d1, d2);
    half(1'b1, 16'h0000);
    half(1'b0, 16'hffff);
    wreg(`STC_OFS_HW_ORDER, `STC_ORDER_SWAP);
    rchk(`STC_OFS_HW_ORDER, `STC_ORDER_SWAP);
    half(1'b1, 16'hffff);
    half(1'b0, 16'h0000);
    @(posedge ref_clk);
    bus16 <= 1'b0;
    half(1'b1, 16'h0000);
    wreg(`STC_OFS_HW_ORDER, 32'h0);
    $display("test free and order done");
  endtask
  task automatic t_drop();
    @(posedge ref_clk);
    go <= 1'b1;
    n <= 8'h03;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rchk(`STC_OFS_DROP, 32'h3);
    rchk(`STC_OFS_DROP, 32'h0);
    $display("test drop done");
  endtask
  task automatic t_data();
    @(posedge ref_clk);
    tx_word <= 32'h89abcdef;
    repeat (2) @(posedge ref_clk);
    #1 chk("tx halves", 32'h89abcdef, {txs, txf});
    chk("rx word", 32'hc3c35a5a, rx_word);
    $display("test data order done");
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_timer();
    t_free();
    t_drop();
    t_data();
    summarize();
  end
endmodule // test_sys_timers_counters_swap
